// [rtl/spec_evict.sv]
// protected page eviction sequencer: checks, header, cipher, write-back
// assumes req and env hold steady from the accept cycle to the check
module spec_evict (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input spec_pkg::spec_req_s req,
  input spec_pkg::spec_env_s env,
  input wire logic cipher_done,
  input wire logic [127:0] cipher_tag,
  output logic busy,
  output logic done,
  output spec_pkg::spec_fault_e fault,
  output logic [63:0] fault_addr,
  output spec_pkg::spec_exit_s exit_info,
  output logic [63:0] result_code_register,
  output spec_pkg::spec_flags_s flags,
  output logic cipher_start,
  output spec_pkg::spec_hdr_s cipher_hdr,
  output logic [95:0] cipher_ctr,
  output logic [63:0] cipher_src,
  output logic [63:0] cipher_dst,
  output logic record_we,
  output logic [63:0] record_addr,
  output spec_pkg::spec_hdr_s record,
  output logic [127:0] record_tag,
  output logic slot_we,
  output logic [63:0] slot_addr,
  output logic [63:0] slot_data,
  output logic map_clr_we,
  output logic [63:0] map_clr_addr
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic misaligned(input logic [63:0] a, input int n);
    logic [63:0] m;
    m = (64'h1 << n) - 64'h1;
    return |(a & m);
  endfunction

  function automatic logic noncanon(input logic [63:0] a);
    return !((&a[63:spec_pkg::CANON_MSB]) || !(|a[63:spec_pkg::CANON_MSB]));
  endfunction

  function automatic logic enclave_owned(input logic [7:0] t);
    return t == spec_pkg::PT_REGULAR || t == spec_pkg::PT_THREAD ||
      t == spec_pkg::PT_TRIMMED || t == spec_pkg::SHADOW_STACK_FIRST_TYPE ||
      t == spec_pkg::SHADOW_STACK_REST_TYPE;
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_CIPHER = 3'h2,
    ST_WAIT = 3'h3,
    ST_WRITE = 3'h4,
    ST_INVAL = 3'h5,
    ST_DONE = 3'h6
  } spec_state_e;

  typedef enum logic [2:0] {
    OC_OK = 3'h0,
    OC_GP = 3'h1,
    OC_PF = 3'h2,
    OC_VMEXIT = 3'h3,
    OC_NOT_BLOCKED = 3'h4,
    OC_UNTRACKED = 3'h5,
    OC_CHILD = 3'h6
  } spec_outcome_e;

  spec_state_e st_q;
  spec_outcome_e oc_d;
  logic [63:0] fa_d;
  spec_pkg::spec_req_s req_q;
  logic occupied_q;
  logic guest_virt;
  logic owned;

  assign guest_virt = env.guest_mode && env.virt_ext;
  assign owned = enclave_owned(env.tgt_type);

  // ----------------------------------------------------------------
  // ordered checks; the first failing one alone decides
  // ----------------------------------------------------------------
  always_comb begin
    oc_d = OC_OK;
    fa_d = 64'h0;
    if (req_q.long_mode && (noncanon(req_q.page_info_pointer) ||
        noncanon(req_q.target_page_pointer) ||
        noncanon(req_q.version_slot_pointer))) begin
      oc_d = OC_GP;
    end else if (misaligned(req_q.page_info_pointer, spec_pkg::PI_ALIGN) ||
        misaligned(req_q.target_page_pointer, spec_pkg::PAGE_ALIGN)) begin
      oc_d = OC_GP;
    end else if (!env.target_in_cache) begin
      oc_d = OC_PF;
      fa_d = req_q.target_page_pointer;
    end else if (misaligned(req_q.version_slot_pointer,
        spec_pkg::SLOT_ALIGN)) begin
      oc_d = OC_GP;
    end else if (!env.slot_in_cache) begin
      oc_d = OC_PF;
      fa_d = req_q.version_slot_pointer;
    end else if (req_q.target_page_pointer[63:spec_pkg::PAGE_ALIGN] ==
        req_q.version_slot_pointer[63:spec_pkg::PAGE_ALIGN]) begin
      oc_d = OC_GP;
    end else if (req_q.pi_linaddr != 64'h0 || req_q.pi_control != 64'h0) begin
      oc_d = OC_GP;
    end else if (misaligned(req_q.pi_record_ptr, spec_pkg::REC_ALIGN) ||
        misaligned(req_q.pi_out_page_ptr, spec_pkg::PAGE_ALIGN) ||
        (req_q.long_mode && (noncanon(req_q.pi_record_ptr) ||
        noncanon(req_q.pi_out_page_ptr)))) begin
      oc_d = OC_GP;
    end else if (env.conflict) begin
      oc_d = guest_virt ? OC_VMEXIT : OC_GP;
    end else if (env.slot_page_busy || env.tracking_busy) begin
      oc_d = OC_GP;
    end else if (!env.tgt_valid) begin
      oc_d = OC_PF;
      fa_d = req_q.target_page_pointer;
    end else if (!env.slot_valid ||
        env.slot_type != spec_pkg::PT_VERSION) begin
      oc_d = OC_PF;
      fa_d = req_q.version_slot_pointer;
    end else if (owned && !env.block_ok) begin
      oc_d = OC_GP;
    end else if (owned && !env.tgt_blocked) begin
      oc_d = OC_NOT_BLOCKED;
    end else if (owned && !env.tracked_ok) begin
      oc_d = OC_UNTRACKED;
    end else if (env.tgt_type == spec_pkg::PT_CONTROL &&
        (env.child_present || (guest_virt && env.virt_child_nz))) begin
      oc_d = OC_CHILD;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        // foreign leaves are not accepted
        ST_IDLE: if (req_valid && req.leaf == spec_pkg::LEAF_EVICT) begin
          st_q <= ST_CHECK;
        end
        ST_CHECK: st_q <= (oc_d == OC_OK) ? ST_CIPHER : ST_DONE;
        ST_CIPHER: st_q <= ST_WAIT;
        ST_WAIT: if (cipher_done) begin
          st_q <= ST_WRITE;
        end
        ST_WRITE: st_q <= ST_INVAL;
        ST_INVAL: st_q <= ST_DONE;
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      if (st_q == ST_IDLE && req_valid && req.leaf == spec_pkg::LEAF_EVICT) begin
        req_q <= req;
      end
      done <= (st_q == ST_DONE);
      if (st_q == ST_IDLE && req_valid &&
          req.leaf == spec_pkg::LEAF_EVICT) begin
        busy <= 1'b1;
      end else if (st_q == ST_DONE) begin
        busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outcome, result code and flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault <= spec_pkg::FLT_NONE;
      fault_addr <= 64'h0;
      exit_info <= '0;
      result_code_register <= spec_pkg::RC_OK;
      flags <= '0;
      occupied_q <= 1'b0;
    end else if (st_q == ST_CHECK) begin
      fault <= spec_pkg::FLT_NONE;
      fault_addr <= fa_d;
      exit_info <= '0;
      occupied_q <= env.slot_value != 64'h0;
      unique case (oc_d)
        OC_GP: fault <= spec_pkg::FLT_GP;
        OC_PF: fault <= spec_pkg::FLT_PF;
        OC_VMEXIT: begin
          fault <= spec_pkg::FLT_VMEXIT;
          exit_info <= '{reason: spec_pkg::EXIT_CONFLICT,
            qual_code: spec_pkg::QUAL_PAGE_CONFLICT, qual_error: 16'h0000,
            guest_phys: env.tgt_guest_phys,
            guest_lin: req_q.target_page_pointer};
        end
        OC_OK: begin
          result_code_register <= spec_pkg::RC_OK;
          flags <= '0;
        end
        OC_NOT_BLOCKED: begin
          result_code_register <= spec_pkg::RC_NOT_BLOCKED;
          flags <= '{zf: 1'b1, default: 1'b0};
        end
        OC_UNTRACKED: begin
          result_code_register <= spec_pkg::RC_UNTRACKED;
          flags <= '{zf: 1'b1, default: 1'b0};
        end
        OC_CHILD: begin
          result_code_register <= spec_pkg::RC_CHILD_PRESENT;
          flags <= '{zf: 1'b1, default: 1'b0};
        end
        default: fault <= spec_pkg::FLT_NONE;
      endcase
    end else if (st_q == ST_WRITE && occupied_q) begin
      // eviction still goes ahead over the old entry
      result_code_register <= spec_pkg::RC_SLOT_OCCUPIED;
      flags <= '{cf: 1'b1, default: 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // header build and cipher launch; key choice lives in the cipher
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cipher_start <= 1'b0;
      cipher_hdr <= '0;
      cipher_ctr <= 96'h0;
      cipher_src <= 64'h0;
      cipher_dst <= 64'h0;
      record <= '0;
    end else begin
      cipher_start <= (st_q == ST_CHECK) && (oc_d == OC_OK);
      if (st_q == ST_CHECK && oc_d == OC_OK) begin
        // header starts all zero, then filled per page type
        cipher_hdr <= '0;
        cipher_hdr.linaddr <= env.tgt_encl_addr;
        cipher_hdr.pt <= env.tgt_type;
        cipher_hdr.rwx <= env.tgt_rwx;
        cipher_hdr.pending <= env.tgt_pending;
        cipher_hdr.modified <= env.tgt_modified;
        cipher_hdr.pr <= env.tgt_pr;
        record <= '0;
        record.linaddr <= env.tgt_encl_addr;
        record.pt <= env.tgt_type;
        record.rwx <= env.tgt_rwx;
        record.pending <= env.tgt_pending;
        record.modified <= env.tgt_modified;
        record.pr <= env.tgt_pr;
        if (owned) begin
          cipher_hdr.enclave_identifier <= env.owner_id;
          record.enclave_identifier <= env.owner_id;
        end else if (env.tgt_type == spec_pkg::PT_CONTROL) begin
          record.enclave_identifier <= env.self_id;
        end
        cipher_ctr <= {env.new_version, 32'h0000_0000};
        cipher_src <= req_q.target_page_pointer;
        cipher_dst <= req_q.pi_out_page_ptr;
      end
    end
  end

  // ----------------------------------------------------------------
  // write-back: record and slot together, map entry one cycle later
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      record_we <= 1'b0;
      record_addr <= 64'h0;
      record_tag <= 128'h0;
      slot_we <= 1'b0;
      slot_addr <= 64'h0;
      slot_data <= 64'h0;
      map_clr_we <= 1'b0;
      map_clr_addr <= 64'h0;
    end else begin
      record_we <= (st_q == ST_WRITE);
      slot_we <= (st_q == ST_WRITE);
      map_clr_we <= (st_q == ST_INVAL);
      if (st_q == ST_WAIT && cipher_done) begin
        record_tag <= cipher_tag;
      end
      if (st_q == ST_WRITE) begin
        record_addr <= req_q.pi_record_ptr;
        slot_addr <= req_q.version_slot_pointer;
        slot_data <= cipher_ctr[95:spec_pkg::CTR_SHIFT];
        map_clr_addr <= req_q.target_page_pointer;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_align_fault: assert property (@(posedge ref_clk) disable iff (reset)
    st_q == ST_CHECK && !req_q.long_mode &&
    misaligned(req_q.page_info_pointer, spec_pkg::PI_ALIGN)
    |=> fault == spec_pkg::FLT_GP ##1 done)
    else $error("misaligned page info did not fault");
  chk_slot_align: assert property (@(posedge ref_clk) disable iff (reset)
    st_q == ST_CHECK && oc_d == OC_GP && env.target_in_cache &&
    misaligned(req_q.version_slot_pointer, spec_pkg::SLOT_ALIGN)
    |=> fault == spec_pkg::FLT_GP)
    else $error("misaligned slot did not fault");
  chk_pf_addr: assert property (@(posedge ref_clk) disable iff (reset)
    st_q == ST_CHECK && !env.target_in_cache &&
    !misaligned(req_q.target_page_pointer, spec_pkg::PAGE_ALIGN) &&
    !misaligned(req_q.page_info_pointer, spec_pkg::PI_ALIGN) &&
    !req_q.long_mode |=> fault == spec_pkg::FLT_PF &&
    fault_addr == req_q.target_page_pointer)
    else $error("page fault address wrong");
  chk_exit_qual: assert property (@(posedge ref_clk) disable iff (reset)
    st_q == ST_CHECK && oc_d == OC_VMEXIT |=>
    exit_info.qual_error == 16'h0000 &&
    exit_info.guest_lin == req_q.target_page_pointer)
    else $error("conflict exit fields wrong");
  chk_abort_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    st_q == ST_CHECK && oc_d != OC_OK |=>
    !cipher_start [*3] ##0 !slot_we && !map_clr_we)
    else $error("state changed after fault or abort");
  chk_zero_flag: assert property (@(posedge ref_clk) disable iff (reset)
    done && flags.zf |-> !flags.cf &&
    (result_code_register == spec_pkg::RC_NOT_BLOCKED ||
    result_code_register == spec_pkg::RC_UNTRACKED ||
    result_code_register == spec_pkg::RC_CHILD_PRESENT))
    else $error("zero flag without its outcome");
  chk_inval_order: assert property (@(posedge ref_clk) disable iff (reset)
    slot_we |=> map_clr_we && !slot_we ##1 done)
    else $error("map entry not cleared after slot write");
  chk_occupied: assert property (@(posedge ref_clk) disable iff (reset)
    slot_we && occupied_q |-> flags.cf &&
    result_code_register == spec_pkg::RC_SLOT_OCCUPIED ##2 done)
    else $error("occupied slot not reported");
  chk_counter: assert property (@(posedge ref_clk) disable iff (reset)
    cipher_start |-> cipher_ctr[31:0] == 32'h0 &&
    $past(env.new_version) == cipher_ctr[95:32])
    else $error("cipher counter not version shifted");

endmodule

// [rtl/spec_pkg.sv]
// constants, types and carriers of the protected page eviction sequencer
// assumes operands arrive already translated; cipher core sits outside
package spec_pkg;

  localparam logic [7:0] LEAF_EVICT = 8'h0B;
  localparam int PI_ALIGN = 5;
  localparam int PAGE_ALIGN = 12;
  localparam int SLOT_ALIGN = 3;
  localparam int REC_ALIGN = 7;
  localparam int CANON_MSB = 47;
  localparam int CTR_SHIFT = 32;
  localparam int HDR_BYTES = 128;
  localparam int PAGE_BYTES = 4096;

  // page types and result codes: encodings of this block
  localparam logic [7:0] PT_CONTROL = 8'h00;
  localparam logic [7:0] PT_REGULAR = 8'h01;
  localparam logic [7:0] PT_THREAD = 8'h02;
  localparam logic [7:0] PT_VERSION = 8'h03;
  localparam logic [7:0] PT_TRIMMED = 8'h04;
  localparam logic [7:0] SHADOW_STACK_FIRST_TYPE = 8'h05;
  localparam logic [7:0] SHADOW_STACK_REST_TYPE = 8'h06;
  localparam logic [63:0] RC_OK = 64'h0;
  localparam logic [63:0] RC_NOT_BLOCKED = 64'h0A;
  localparam logic [63:0] RC_UNTRACKED = 64'h0B;
  localparam logic [63:0] RC_SLOT_OCCUPIED = 64'h0C;
  localparam logic [63:0] RC_CHILD_PRESENT = 64'h0D;
  localparam logic [15:0] EXIT_CONFLICT = 16'h003F;
  localparam logic [15:0] QUAL_PAGE_CONFLICT = 16'h0000;

  typedef enum logic [1:0] {
    FLT_NONE = 2'h0,
    FLT_GP = 2'h1,
    FLT_PF = 2'h2,
    FLT_VMEXIT = 2'h3
  } spec_fault_e;

  typedef struct packed {
    logic [7:0] leaf;
    logic long_mode;
    logic [63:0] page_info_pointer;
    logic [63:0] target_page_pointer;
    logic [63:0] version_slot_pointer;
    logic [63:0] pi_linaddr;
    logic [63:0] pi_control;
    logic [63:0] pi_record_ptr;
    logic [63:0] pi_out_page_ptr;
  } spec_req_s;

  typedef struct packed {
    logic target_in_cache;
    logic slot_in_cache;
    logic conflict;
    logic guest_mode;
    logic virt_ext;
    logic slot_page_busy;
    logic tracking_busy;
    logic tgt_valid;
    logic tgt_blocked;
    logic [7:0] tgt_type;
    logic [2:0] tgt_rwx;
    logic tgt_pending;
    logic tgt_modified;
    logic tgt_pr;
    logic [63:0] tgt_encl_addr;
    logic [63:0] tgt_guest_phys;
    logic slot_valid;
    logic [7:0] slot_type;
    logic block_ok;
    logic tracked_ok;
    logic child_present;
    logic virt_child_nz;
    logic [63:0] owner_id;
    logic [63:0] self_id;
    logic [63:0] slot_value;
    logic [63:0] new_version;
  } spec_env_s;

  typedef struct packed {
    logic [63:0] enclave_identifier;
    logic [63:0] linaddr;
    logic [7:0] pt;
    logic [2:0] rwx;
    logic pending;
    logic modified;
    logic pr;
  } spec_hdr_s;

  typedef struct packed {
    logic [15:0] reason;
    logic [15:0] qual_code;
    logic [15:0] qual_error;
    logic [63:0] guest_phys;
    logic [63:0] guest_lin;
  } spec_exit_s;

  typedef struct packed {
    logic of;
    logic sf;
    logic zf;
    logic af;
    logic pf;
    logic cf;
  } spec_flags_s;

endpackage

// [verif/spec_cipher_model.sv]
// cipher stand-in facing the eviction sequencer's cipher port
// assumes start is a one-cycle pulse and ctr stands until done
module spec_cipher_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cipher_start,
  input wire logic [95:0] cipher_ctr,
  input wire logic [3:0] lat,
  output logic cipher_done,
  output logic [127:0] cipher_tag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic run_q;
  initial begin
    cipher_done = 1'b0;
    cipher_tag = '0;
  end
  // tag is only valid with done; otherwise it toggles so stale use shows
  always @(posedge ref_clk) begin
    cipher_done <= 1'b0;
    cipher_tag <= ~cipher_tag;
    if (reset) begin
      run_q <= 1'b0;
      cnt_q <= 4'h0;
      cipher_tag <= '0;
    end else if (cipher_start) begin
      run_q <= 1'b1;
      cnt_q <= lat;
    end else if (run_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (run_q) begin
      run_q <= 1'b0;
      cipher_done <= 1'b1;
      cipher_tag <= {cipher_ctr, 32'h5A5AA5A5};
    end
  end
endmodule

// [verif/secure_page_evict_checker_tb_top.sv]
// self-checking bench of the page eviction sequencer
// assumes spec_pkg, spec_evict and the cipher stand-in compile first
module secure_page_evict_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    spec_pkg::spec_fault_e f;
    logic [63:0] fa;
    logic [63:0] rc;
    logic zf;
    logic cf;
    logic wr;
  } spec_exp_s;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  spec_pkg::spec_req_s req = '0;
  spec_pkg::spec_env_s env = '0;
  logic [3:0] lat = 4'h0;
  logic cipher_done, busy, done, cipher_start, record_we, slot_we;
  logic map_clr_we;
  logic [63:0] fault_addr, result_code_register, cipher_src, cipher_dst;
  logic [63:0] record_addr, slot_addr, slot_data, map_clr_addr;
  logic [95:0] cipher_ctr, c_ctr;
  logic [127:0] cipher_tag, record_tag, c_tag;
  spec_pkg::spec_fault_e fault;
  spec_pkg::spec_exit_s exit_info;
  spec_pkg::spec_flags_s flags;
  spec_pkg::spec_hdr_s cipher_hdr, record, c_hdr, c_rec;
  logic [63:0] c_src, c_dst, c_ra, c_sa, c_sd, c_ca;
  logic [31:0] seed = 32'h9D5D98A8;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int s_cyc, c_cyc;
  int pc [5];

  spec_evict i_dut (.ref_clk, .reset, .req_valid, .req, .env,
    .cipher_done, .cipher_tag, .busy, .done, .fault, .fault_addr,
    .exit_info, .result_code_register, .flags, .cipher_start,
    .cipher_hdr, .cipher_ctr, .cipher_src, .cipher_dst, .record_we,
    .record_addr, .record, .record_tag, .slot_we, .slot_addr,
    .slot_data, .map_clr_we, .map_clr_addr);
  spec_cipher_model i_cipher (.ref_clk, .reset, .cipher_start,
    .cipher_ctr, .lat, .cipher_done, .cipher_tag);

  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------
  // helpers and expectation
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction

  function automatic logic coin();
    return rnd() % 2 == 0;
  endfunction

  function automatic logic nc(input logic [63:0] a);
    return a[63:47] != {17{a[47]}};
  endfunction

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // first failing check decides; codes 2 and 3 page-fault on an operand
  function automatic spec_exp_s predict(input spec_pkg::spec_req_s r,
    input spec_pkg::spec_env_s e);
    spec_exp_s x;
    logic [2:0] c;
    logic own;
    logic [63:0] tp;
    logic [63:0] sp;
    x = '0;
    tp = r.target_page_pointer;
    sp = r.version_slot_pointer;
    own = e.tgt_type != spec_pkg::PT_CONTROL &&
      e.tgt_type != spec_pkg::PT_VERSION;
    c = 3'h0;
    if (r.long_mode && (nc(r.page_info_pointer) || nc(tp) || nc(sp)))
      c = 3'h1;
    else if (r.page_info_pointer[4:0] != 5'h0 || tp[11:0] != 12'h0)
      c = 3'h1;
    else if (!e.target_in_cache)
      c = 3'h2;
    else if (sp[2:0] != 3'h0)
      c = 3'h1;
    else if (!e.slot_in_cache)
      c = 3'h3;
    else if (tp[63:12] == sp[63:12])
      c = 3'h1;
    else if (r.pi_linaddr != 64'h0 || r.pi_control != 64'h0)
      c = 3'h1;
    else if (r.pi_record_ptr[6:0] != 7'h0 || r.pi_out_page_ptr[11:0] != 0)
      c = 3'h1;
    else if (r.long_mode && (nc(r.pi_record_ptr) || nc(r.pi_out_page_ptr)))
      c = 3'h1;
    else if (e.conflict)
      c = (e.guest_mode && e.virt_ext) ? 3'h4 : 3'h1;
    else if (e.slot_page_busy || e.tracking_busy)
      c = 3'h1;
    else if (!e.tgt_valid)
      c = 3'h2;
    else if (!e.slot_valid || e.slot_type != spec_pkg::PT_VERSION)
      c = 3'h3;
    else if (own && !e.block_ok)
      c = 3'h1;
    x.f = c == 3'h0 ? spec_pkg::FLT_NONE : c == 3'h4 ? spec_pkg::FLT_VMEXIT :
      c == 3'h1 ? spec_pkg::FLT_GP : spec_pkg::FLT_PF;
    x.fa = c == 3'h2 ? tp : c == 3'h3 ? sp : 64'h0;
    if (own && !e.tgt_blocked)
      x.rc = spec_pkg::RC_NOT_BLOCKED;
    else if (own && !e.tracked_ok)
      x.rc = spec_pkg::RC_UNTRACKED;
    else if (e.tgt_type == spec_pkg::PT_CONTROL && (e.child_present ||
        (e.guest_mode && e.virt_ext && e.virt_child_nz)))
      x.rc = spec_pkg::RC_CHILD_PRESENT;
    else if (e.slot_value != 64'h0)
      x.rc = spec_pkg::RC_SLOT_OCCUPIED;
    x.cf = x.rc == spec_pkg::RC_SLOT_OCCUPIED;
    x.zf = x.rc != 64'h0 && !x.cf;
    x.wr = c == 3'h0 && !x.zf;
    return x;
  endfunction

  // ----------------------------------------
  // stimulus and per-operation checks
  // ----------------------------------------
  task automatic build();
    req = '0;
    env = '0;
    req.leaf = spec_pkg::LEAF_EVICT;
    req.long_mode = coin();
    req.page_info_pointer = {32'h0, rnd() & 32'hFFFFFFE0};
    req.target_page_pointer = {32'h0, rnd() & 32'hFFFFF000};
    req.version_slot_pointer = {32'h0, rnd() & 32'hFFFFFFF8};
    req.version_slot_pointer[12] = ~req.target_page_pointer[12];
    req.pi_record_ptr = {32'h0, rnd() & 32'hFFFFFF80};
    req.pi_out_page_ptr = {32'h0, rnd() & 32'hFFFFF000};
    env.target_in_cache = 1'b1;
    env.slot_in_cache = 1'b1;
    env.guest_mode = coin();
    env.virt_ext = coin();
    env.tgt_valid = 1'b1;
    env.tgt_blocked = 1'b1;
    env.tgt_type = 8'(rnd() % 7);
    env.tgt_rwx = 3'(rnd());
    env.tgt_pending = coin();
    env.tgt_modified = coin();
    env.tgt_pr = coin();
    env.tgt_encl_addr = {rnd(), rnd()};
    env.tgt_guest_phys = {rnd(), rnd()};
    env.slot_valid = 1'b1;
    env.slot_type = spec_pkg::PT_VERSION;
    env.block_ok = 1'b1;
    env.tracked_ok = 1'b1;
    env.owner_id = {rnd(), rnd()};
    env.self_id = {rnd(), rnd()};
    env.slot_value = coin() ? 64'h0 : {rnd(), rnd()};
    env.new_version = {rnd(), rnd()};
  endtask

  task automatic corrupt(input int k);
    case (k)
      1: req.page_info_pointer[62] = 1'b1;
      2: req.target_page_pointer[61] = 1'b1;
      3: req.version_slot_pointer[60] = 1'b1;
      4: req.pi_record_ptr[59] = 1'b1;
      5: req.pi_out_page_ptr[58] = 1'b1;
      6: req.page_info_pointer[4] = 1'b1;
      7: req.target_page_pointer[11] = 1'b1;
      8: env.target_in_cache = 1'b0;
      9: req.version_slot_pointer[2] = 1'b1;
      10: env.slot_in_cache = 1'b0;
      11: req.version_slot_pointer[63:12] = req.target_page_pointer[63:12];
      12: req.pi_linaddr[0] = 1'b1;
      13: req.pi_control[40] = 1'b1;
      14: req.pi_record_ptr[6] = 1'b1;
      15: req.pi_out_page_ptr[0] = 1'b1;
      16: env.conflict = 1'b1;
      17: env.slot_page_busy = 1'b1;
      18: env.tracking_busy = 1'b1;
      19: env.tgt_valid = 1'b0;
      20: env.slot_valid = 1'b0;
      21: env.slot_type = spec_pkg::PT_REGULAR;
      22: env.block_ok = 1'b0;
      23: env.tgt_blocked = 1'b0;
      24: env.tracked_ok = 1'b0;
      25: env.child_present = 1'b1;
      26: env.virt_child_nz = 1'b1;
      default: ;
    endcase
  endtask

  // odd cases hold the strobe while busy: it must not start a second run
  task automatic run_op(input int k);
    spec_exp_s x;
    spec_pkg::spec_hdr_s eh;
    spec_pkg::spec_hdr_s er;
    spec_pkg::spec_exit_s ex;
    logic own;
    int n;
    build();
    corrupt(k);
    if (coin())
      corrupt(rnd() % 27);
    x = predict(req, env);
    own = env.tgt_type != spec_pkg::PT_CONTROL &&
      env.tgt_type != spec_pkg::PT_VERSION;
    eh = {own ? env.owner_id : 64'h0, env.tgt_encl_addr, env.tgt_type,
      env.tgt_rwx, env.tgt_pending, env.tgt_modified, env.tgt_pr};
    er = eh;
    er.enclave_identifier = own ? env.owner_id :
      env.tgt_type == spec_pkg::PT_CONTROL ? env.self_id : 64'h0;
    ex = '0;
    if (x.f == spec_pkg::FLT_VMEXIT)
      ex = {spec_pkg::EXIT_CONFLICT, spec_pkg::QUAL_PAGE_CONFLICT, 16'h0,
        env.tgt_guest_phys, req.target_page_pointer};
    lat = 4'(rnd() % 8);
    pc = '{default: 0};
    req_valid = 1'b1;
    repeat (1 + 2 * (k % 2)) begin
      @(posedge ref_clk);
      #1;
    end
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    #1;
    chk(n < 200 && pc[4] == 1, "one done per request");
    chk(fault === x.f, "fault kind");
    chk(fault_addr === x.fa, "fault address");
    chk(exit_info === ex, "exit record");
    if (x.f == spec_pkg::FLT_NONE) begin
      chk(result_code_register === x.rc, "result code");
      chk(flags === {2'h0, x.zf, 2'h0, x.cf}, "flags");
    end
    chk(pc[0] == x.wr && pc[1] == x.wr && pc[3] == x.wr, "side effects");
    chk(pc[2] == x.wr, "slot write count");
    if (x.wr) begin
      chk(c_hdr === eh && c_rec === er, "identifiers");
      chk(c_ctr === {env.new_version, 32'h0}, "counter");
      chk(c_src === req.target_page_pointer, "source page");
      chk(c_dst === req.pi_out_page_ptr, "output page");
      chk(c_ra === req.pi_record_ptr && c_tag === {c_ctr, 32'h5A5AA5A5},
        "record");
      chk(c_sa === req.version_slot_pointer && c_sd === env.new_version,
        "slot");
      chk(c_ca === req.target_page_pointer && c_cyc > s_cyc, "map");
    end
  endtask

  // ----------------------------------------
  // monitor, watchdog and main sequence
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (done === 1'b1)
      pc[4]++;
    if (cipher_start === 1'b1) begin
      pc[0]++;
      c_hdr = cipher_hdr;
      c_ctr = cipher_ctr;
      c_src = cipher_src;
      c_dst = cipher_dst;
    end
    if (record_we === 1'b1) begin
      pc[1]++;
      c_rec = record;
      c_tag = record_tag;
      c_ra = record_addr;
    end
    if (slot_we === 1'b1) begin
      pc[2]++;
      c_sa = slot_addr;
      c_sd = slot_data;
      s_cyc = cyc;
    end
    if (map_clr_we === 1'b1) begin
      pc[3]++;
      c_ca = map_clr_addr;
      c_cyc = cyc;
    end
    if (cyc == 20000) begin
      failures++;
      $display("[ERR] %0t run hung", $time);
      complete_run();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    @(posedge ref_clk);
    #1;
    build();
    req.leaf = 8'h0C;
    req_valid = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(busy === 1'b0, "other leaf taken");
    req_valid = 1'b0;
    for (int i = 0; i < 324; i++)
      run_op(i % 27);
    build();
    req_valid = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    reset = 1'b1;
    @(posedge ref_clk);
    #1;
    chk(busy === 1'b0 && fault === spec_pkg::FLT_NONE, "reset");
    reset = 1'b0;
    @(posedge ref_clk);
    #1;
    run_op(0);
    complete_run();
  end
endmodule
